/* design/autocfg_defines.svh */
// register offsets, field positions, reset values and search counts
// Functional notes
// R1: host-written 8-bit search target value
// R2: host-written 8-bit search lower bound
// R3: host-written 8-bit search upper bound
// R4: host sets target near ninety percent of upper
// R5: host sets lower near sixty-five percent scale
// R6: bits 7:6 give first stage sample count
// R7: bits 5:4 zero disables retry, else enabled
// R8: bits 3:2 pick baseline action on completion
// R9: control bit 1 enables automatic reconfiguration
// R10: control bit 0 enables initial configuration
// R11: drift outside limits starts a reconfiguration
// R12: host normally writes 0x0b to control
// R13: host prefers truncated baseline load over exact
// R14: failed search raises the out-of-range indication
// R15: failure cause recorded per configuration kind
// R16: reconfig flag bit 7, initial flag bit 6
// R17: per-electrode out-of-range bits, electrodes 0-7
// R18: search picks charge current and time itself
// R19: per-electrode search, bit updated every cycle end
`ifndef AUTOCFG_DEFINES_SVH
`define AUTOCFG_DEFINES_SVH
`define ELE_COUNT      8
`define OFS_TARGET     8'h00
`define OFS_LOWER      8'h04
`define OFS_UPPER      8'h08
`define OFS_CTRL       8'h0c
`define OFS_RANGE_STS  8'h10
`define OFS_FAIL_STS   8'h14
`define OFS_IRQ_STS    8'h18
`define OFS_IRQ_MASK   8'h1c
`define TARGET_RST     8'h00
`define LOWER_RST      8'h00
`define UPPER_RST      8'h00
`define CTRL_RST       8'h00
`define FAIL_RECFG_BIT 7
`define FAIL_INIT_BIT  6
`define CTRL_INIT_BIT  0
`define IRQ_DONE_BIT   0
`define IRQ_FAIL_BIT   1
`define FS_COUNT_0     6'h06
`define FS_COUNT_1     6'h0a
`define FS_COUNT_2     6'h12
`define FS_COUNT_3     6'h22
`define CUR_START      6'h20
`define TIME_FIRST     3'h1
`define TIME_LAST      3'h7
`define SAR_STEPS      3'h6
`endif

/* design/autocfg_pkg.sv */
// shared types of the auto-configuration block
package autocfg_pkg;
  typedef enum logic [1:0] {
    BVA_KEEP  = 2'b00,
    BVA_CLEAR = 2'b01,
    BVA_TRUNC = 2'b10,
    BVA_LOAD  = 2'b11
  } bva_e;
  typedef struct packed {
    logic [1:0] first_stage_count_copy;
    logic [1:0] retry;
    bva_e       baseline_adjust_select;
    logic       reconfig_enable;
    logic       initial_config_enable;
  } ctrl_s;
  typedef struct packed {
    logic [2:0] charge_time_code;
    logic [5:0] charge_current_code;
  } ele_setting_s;
  typedef struct packed {
    logic [2:0]   ele;
    ele_setting_s setting;
    logic [5:0]   samples;
  } meas_cmd_s;
  typedef struct packed {
    logic       load;
    logic [2:0] ele;
    logic [7:0] value;
  } base_load_s;
  typedef enum logic [1:0] {SRCH_IDLE = 2'b01, SRCH_BUSY = 2'b10} srch_e;
  typedef enum logic [1:0] {SCH_IDLE = 2'b01, SCH_RUN = 2'b10} sch_e;
endpackage

/* design/cfg_search.sv */
// charge current and charge time search for one electrode
`timescale 1ns/1ns
`include "autocfg_defines.svh"
module cfg_search (
  input  logic                      clk_sys,    // system clock
  input  logic                      rst_n,      // async reset
  input  logic                      start,      // begin search
  input  logic                      meas_valid, // sample ready
  input  logic [7:0]                meas_data,  // sample value
  input  logic [7:0]                target,     // aim level
  input  logic [7:0]                lower,      // lower bound
  input  logic [7:0]                upper,      // upper bound
  output logic                      req,        // sample wanted
  output autocfg_pkg::ele_setting_s setting,    // trial setting
  output logic                      done,       // end pulse
  output logic                      ok,         // within limits
  output logic [7:0]                result      // last sample
);
  autocfg_pkg::srch_e st_q;
  logic [2:0]         time_q;
  logic [5:0]         cur_q;
  logic [2:0]         step_q;
  logic               in_rng;
  logic [5:0]         bit_m;

  range_check u_rc (
    .value    (meas_data),
    .lower    (lower),
    .upper    (upper),
    .in_range (in_rng)
  );

  assign bit_m = `CUR_START >> step_q;
  assign req = (st_q == autocfg_pkg::SRCH_BUSY);
  assign setting = {time_q, cur_q};

  // successive approximation on current, then next charge time [R18]
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q   <= autocfg_pkg::SRCH_IDLE;
      time_q <= `TIME_FIRST;
      cur_q  <= `CUR_START;
      step_q <= 3'h0;
      done   <= 1'b0;
      ok     <= 1'b0;
      result <= 8'h00;
    end
    else
    begin
      done <= 1'b0;
      unique case (st_q)
        autocfg_pkg::SRCH_IDLE:
          if (start)
          begin
            st_q   <= autocfg_pkg::SRCH_BUSY;
            time_q <= `TIME_FIRST;
            cur_q  <= `CUR_START;
            step_q <= 3'h0;
          end
        autocfg_pkg::SRCH_BUSY:
          if (meas_valid)
          begin
            result <= meas_data;
            if (step_q != `SAR_STEPS)
            begin
              // too high drops the trial bit; next lower bit is tried
              cur_q  <= ((meas_data > target) ? (cur_q & ~bit_m) : cur_q) | (bit_m >> 1);
              step_q <= step_q + 3'h1;
            end
            else if (in_rng || (time_q == `TIME_LAST))
            begin
              done <= 1'b1;
              ok   <= in_rng;  // [R14]
              st_q <= autocfg_pkg::SRCH_IDLE;
            end
            else
            begin
              time_q <= time_q + 3'h1;
              cur_q  <= `CUR_START;
              step_q <= 3'h0;
            end
          end
      endcase
    end
  end
endmodule

/* design/range_check.sv */
// window compare of one value against the search limits
`timescale 1ns/1ns
module range_check (
  input  logic [7:0] value,    // sample or baseline
  input  logic [7:0] lower,    // lower bound
  input  logic [7:0] upper,    // upper bound
  output logic       in_range  // inside window
);
  // an inverted window can never pass [R14]
  assign in_range = (value >= lower) && (value <= upper);
endmodule

/* design/touch_autoconfig_control.sv */
// auto-configuration control with avalon-mm register slave
`timescale 1ns/1ns
`include "autocfg_defines.svh"
module touch_autoconfig_control (
  input  logic                            clk_sys,     // system clock
  input  logic                            rst_n,       // async reset
  input  logic [7:0]                      address,     // byte address
  input  logic                            read,        // read request
  input  logic                            write,       // write request
  input  logic [31:0]                     writedata,   // write data
  input  logic [3:0]                      byteenable,  // lane enables
  output logic [31:0]                     readdata,    // read data
  output logic                            waitrequest, // bus stall
  output logic                            irq,         // level irq
  output logic                            meas_req,    // sample wanted
  output autocfg_pkg::meas_cmd_s          meas_cmd,    // sample setup
  input  logic                            meas_valid,  // sample ready
  input  logic [7:0]                      meas_data,   // sample value
  input  logic [7:0][7:0]                 baseline,    // live baselines
  output autocfg_pkg::base_load_s         base_load,   // baseline write
  output autocfg_pkg::ele_setting_s [7:0] setting,     // chosen settings
  output logic                            busy         // search running
);
  logic [7:0]                      target_q;
  logic [7:0]                      lower_q;
  logic [7:0]                      upper_q;
  autocfg_pkg::ctrl_s              ctrl_q;
  logic [7:0]                      oor_q;
  logic                            fail_init_q;
  logic                            fail_recfg_q;
  logic [1:0]                      irq_sts_q;
  logic [1:0]                      irq_mask_q;
  logic [7:0]                      init_pend_q;
  logic [7:0]                      recfg_pend_q;
  autocfg_pkg::sch_e               sch_q;
  logic [2:0]                      ele_q;
  logic                            is_recfg_q;
  logic                            retried_q;
  autocfg_pkg::ele_setting_s [7:0] setting_q;
  autocfg_pkg::base_load_s         base_q;
  logic [5:0]                      samples_q;
  logic                            ack_q;
  logic [7:0]                      rd_q;
  logic [7:0]                      rd_mux;
  logic [7:0]                      reg_addr;
  logic                            wr_go;
  logic [7:0]                      wr_byte;
  logic [7:0]                      fail_vec;
  logic [7:0]                      in_rng;
  logic [7:0]                      pend;
  logic [2:0]                      pick;
  logic                            start;
  logic                            srch_req;
  autocfg_pkg::ele_setting_s       srch_setting;
  logic                            srch_done;
  logic                            srch_ok;
  logic [7:0]                      srch_result;
  logic                            retry_go;
  logic [7:0]                      ele_mask;
  logic [7:0]                      done_clr;
  logic [7:0]                      recfg_set;
  logic [1:0]                      irq_evt;

  // lowest pending electrode goes first
  function automatic logic [2:0] first_set(input logic [7:0] v);
    first_set = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
        first_set = i[2:0];
    end
  endfunction

  // sample count of the first filter stage [R6]
  function automatic logic [5:0] fs_samples(input logic [1:0] code);
    unique case (code)
      2'b00: fs_samples = `FS_COUNT_0;
      2'b01: fs_samples = `FS_COUNT_1;
      2'b10: fs_samples = `FS_COUNT_2;
      2'b11: fs_samples = `FS_COUNT_3;
    endcase
  endfunction

  // write strobe for one register offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = wr_go && (reg_addr == ofs);
  endfunction

  // bus slave: one wait cycle, then the answer
  assign reg_addr = {address[7:2], 2'b00};
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_go = write & ack_q & byteenable[0];
  assign wr_byte = writedata[7:0];
  assign readdata = {24'h000000, rd_q};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= (read | write) & ~ack_q;
  end

  // fail flags sit in the top bits of their word [R16]
  always_comb
  begin
    fail_vec = 8'h00;
    fail_vec[`FAIL_RECFG_BIT] = fail_recfg_q;
    fail_vec[`FAIL_INIT_BIT] = fail_init_q;
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 8'h00;
    case (reg_addr)
      `OFS_TARGET:    rd_mux = target_q;
      `OFS_LOWER:     rd_mux = lower_q;
      `OFS_UPPER:     rd_mux = upper_q;
      `OFS_CTRL:      rd_mux = ctrl_q;
      `OFS_RANGE_STS: rd_mux = oor_q;  // [R17]
      `OFS_FAIL_STS:  rd_mux = fail_vec;
      `OFS_IRQ_STS:   rd_mux = {6'h00, irq_sts_q};
      `OFS_IRQ_MASK:  rd_mux = {6'h00, irq_mask_q};
      default:        rd_mux = 8'h00;
    endcase
  end

  // read data captured on the wait cycle, stable at the answer edge
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rd_q <= 8'h00;
    else if (read & ~ack_q)
      rd_q <= rd_mux;
  end

  // host limits and target, every code accepted
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      target_q <= `TARGET_RST;
      lower_q  <= `LOWER_RST;
      upper_q  <= `UPPER_RST;
    end
    else
    begin
      if (wr_hit(`OFS_TARGET))
        target_q <= wr_byte;  // [R1]
      if (wr_hit(`OFS_LOWER))
        lower_q <= wr_byte;  // [R2]
      if (wr_hit(`OFS_UPPER))
        upper_q <= wr_byte;  // [R3]
    end
  end

  // control word; sample count copied for the front end [R6]
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q    <= autocfg_pkg::ctrl_s'(`CTRL_RST);
      samples_q <= `FS_COUNT_0;
    end
    else
    begin
      if (wr_hit(`OFS_CTRL))
        ctrl_q <= autocfg_pkg::ctrl_s'(wr_byte);
      samples_q <= fs_samples(ctrl_q.first_stage_count_copy);  // [R6]
    end
  end

  // drift watch on every electrode baseline [R11]
  for (genvar g = 0; g < `ELE_COUNT; g++)
  begin : g_drift
    range_check u_rc (
      .value    (baseline[g]),
      .lower    (lower_q),
      .upper    (upper_q),
      .in_range (in_rng[g])
    );
  end

  cfg_search u_search (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .start      (start),
    .meas_valid (meas_valid),
    .meas_data  (meas_data),
    .target     (target_q),
    .lower      (lower_q),
    .upper      (upper_q),
    .req        (srch_req),
    .setting    (srch_setting),
    .done       (srch_done),
    .ok         (srch_ok),
    .result     (srch_result)
  );

  // scheduling terms; retry allows one extra pass [R7]
  assign pend = init_pend_q | recfg_pend_q;
  assign pick = first_set(pend);
  assign busy = (sch_q == autocfg_pkg::SCH_RUN);
  assign start = (sch_q == autocfg_pkg::SCH_IDLE) && (|pend);
  assign ele_mask = 8'h01 << ele_q;
  assign retry_go = ~srch_ok & (|ctrl_q.retry) & ~retried_q;  // [R7]
  assign done_clr = (srch_done & ~retry_go) ? ele_mask : 8'h00;
  // a failed electrode is not re-armed, else it would loop forever
  assign recfg_set = {8{ctrl_q.reconfig_enable}} & ~in_rng & ~oor_q
                     & ~(busy ? ele_mask : 8'h00);  // [R9] [R11]

  // initial configuration armed by writing the enable bit [R10]
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      init_pend_q <= 8'h00;
    else if (wr_hit(`OFS_CTRL))
      init_pend_q <= wr_byte[`CTRL_INIT_BIT] ? 8'hff : 8'h00;  // [R10]
    else
      init_pend_q <= init_pend_q & ~done_clr;
  end

  // reconfiguration requests; a clear wins, as the searched electrode cannot be set while busy [R11]
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      recfg_pend_q <= 8'h00;
    else if (!ctrl_q.reconfig_enable)
      recfg_pend_q <= 8'h00;  // [R9]
    else
      recfg_pend_q <= (recfg_pend_q & ~done_clr) | recfg_set;
  end

  // one electrode at a time, each with its own search [R19]
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sch_q      <= autocfg_pkg::SCH_IDLE;
      ele_q      <= 3'h0;
      is_recfg_q <= 1'b0;
      retried_q  <= 1'b0;
    end
    else
    begin
      unique case (sch_q)
        autocfg_pkg::SCH_IDLE:
          if (|pend)
          begin
            sch_q      <= autocfg_pkg::SCH_RUN;
            ele_q      <= pick;
            is_recfg_q <= ~init_pend_q[pick];  // [R15]
            retried_q  <= retried_q && (pick == ele_q);
          end
        autocfg_pkg::SCH_RUN:
          if (srch_done)
          begin
            sch_q     <= autocfg_pkg::SCH_IDLE;
            retried_q <= retry_go;  // [R7]
          end
      endcase
    end
  end

  // per-electrode result and chosen setting [R17] [R18] [R19]
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oor_q     <= 8'h00;
      setting_q <= '0;
    end
    else if (srch_done)
    begin
      oor_q[ele_q]     <= ~srch_ok;  // [R14] [R19]
      setting_q[ele_q] <= srch_setting;  // [R18]
    end
  end

  // failure cause; cleared when initial configuration is re-armed, a failing search in that cycle wins
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_init_q  <= 1'b0;
      fail_recfg_q <= 1'b0;
    end
    else if (srch_done && !srch_ok)
    begin
      fail_init_q  <= fail_init_q | ~is_recfg_q;  // [R15]
      fail_recfg_q <= fail_recfg_q | is_recfg_q;  // [R15]
    end
    else if (wr_hit(`OFS_CTRL) && wr_byte[`CTRL_INIT_BIT])
    begin
      fail_init_q  <= 1'b0;
      fail_recfg_q <= 1'b0;
    end
  end

  // baseline action when a search passes [R8]
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      base_q <= '0;
    else
    begin
      base_q.load <= 1'b0;
      if (srch_done && srch_ok)
      begin
        base_q.ele <= ele_q;
        unique case (ctrl_q.baseline_adjust_select)
          autocfg_pkg::BVA_KEEP:
            base_q.load <= 1'b0;
          autocfg_pkg::BVA_CLEAR:
          begin
            base_q.load  <= 1'b1;
            base_q.value <= 8'h00;
          end
          autocfg_pkg::BVA_TRUNC:
          begin
            // sits at or below the data, so no false touch at start
            base_q.load  <= 1'b1;
            base_q.value <= {srch_result[7:3], 3'h0};
          end
          autocfg_pkg::BVA_LOAD:
          begin
            base_q.load  <= 1'b1;
            base_q.value <= srch_result;
          end
        endcase
      end
    end
  end

  // sticky events, write one to clear, a new event wins
  assign irq_evt = {srch_done & ~srch_ok, srch_done};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_sts_q  <= 2'h0;
      irq_mask_q <= 2'h0;
    end
    else
    begin
      irq_sts_q <= (irq_sts_q & ~(wr_hit(`OFS_IRQ_STS) ? wr_byte[1:0] : 2'h0)) | irq_evt;
      if (wr_hit(`OFS_IRQ_MASK))
        irq_mask_q <= wr_byte[1:0];
    end
  end

  assign irq = |(irq_sts_q & irq_mask_q);

  // front-end request and result outputs
  assign meas_req = srch_req;
  assign meas_cmd = {ele_q, srch_setting, samples_q};
  assign setting = setting_q;
  assign base_load = base_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_done_fail;
    srch_done && !srch_ok;
  endsequence

  sequence s_done_ok;
    srch_done && srch_ok;
  endsequence

  a_oor_on_fail: assert property (s_done_fail |=> oor_q[$past(ele_q)]) // [R17] [R19]
    else $error("range bit not set after failed search");
  a_oor_on_pass: assert property (s_done_ok |=> !oor_q[$past(ele_q)]) // [R19]
    else $error("range bit not cleared after passing search");
  a_init_fail_flag: assert property (s_done_fail ##0 !is_recfg_q |=> fail_init_q) // [R15] [R16]
    else $error("initial fail flag missing");
  a_recfg_fail_flag: assert property (s_done_fail ##0 is_recfg_q |=> fail_recfg_q) // [R15] [R16]
    else $error("reconfiguration fail flag missing");
  a_pass_in_limits: assert property (s_done_ok |->
    srch_result >= $past(lower_q) && srch_result <= $past(upper_q)) // [R14]
    else $error("passing search outside limits");
  a_bva_clear: assert property (s_done_ok ##0
    ctrl_q.baseline_adjust_select == autocfg_pkg::BVA_CLEAR
    |=> base_q.load && base_q.value == 8'h00) // [R8]
    else $error("baseline not cleared");
  a_bva_trunc: assert property (s_done_ok ##0
    ctrl_q.baseline_adjust_select == autocfg_pkg::BVA_TRUNC
    |=> base_q.load && base_q.value == {$past(srch_result[7:3]), 3'h0}) // [R8]
    else $error("truncated baseline wrong");
  a_bva_keep: assert property (s_done_ok ##0
    ctrl_q.baseline_adjust_select == autocfg_pkg::BVA_KEEP |=> !base_q.load) // [R8]
    else $error("baseline changed with keep code");
  a_recfg_needs_en: assert property ((|(recfg_pend_q & ~$past(recfg_pend_q)))
    |-> $past(ctrl_q.reconfig_enable)) // [R9] [R11]
    else $error("reconfiguration armed while disabled");
  a_init_needs_write: assert property ((|(init_pend_q & ~$past(init_pend_q)))
    |-> $past(wr_go && (reg_addr == `OFS_CTRL) && wr_byte[`CTRL_INIT_BIT])) // [R10]
    else $error("initial configuration armed without enable write");
  a_retry_off: assert property (s_done_fail ##0 ctrl_q.retry == 2'b00
    ##0 !is_recfg_q ##0 !wr_go |=> !init_pend_q[$past(ele_q)]) // [R7]
    else $error("retry taken while disabled");
  a_setting_kept: assert property (srch_done |=>
    setting_q[$past(ele_q)] == $past(srch_setting)) // [R18]
    else $error("chosen setting not stored");
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer later than one wait cycle");
endmodule

/* dv/frontend_model.sv */
// behavioural front end answering sample requests of the search
`timescale 1ns/1ns
module frontend_model (
  input  logic                   clk_sys,    // system clock
  input  logic                   rst_n,      // async reset
  input  logic                   meas_req,   // sample wanted
  input  autocfg_pkg::meas_cmd_s meas_cmd,   // sample setup
  input  logic [7:0]             level,      // value to report
  input  logic [1:0]             lag,        // answer delay in cycles
  output logic                   meas_valid, // sample pulse
  output logic [7:0]             meas_data   // sample value
);
  logic [1:0] cnt_q;
  // one pulse per request after lag cycles; data toggles after each pulse and
  // holds during the lag count, so a design that samples off the pulse reads a stale value
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meas_valid <= 1'b0;
      meas_data  <= 8'h00;
      cnt_q      <= 2'h0;
    end
    else if (meas_valid || !meas_req)
    begin
      meas_valid <= 1'b0;
      meas_data  <= ~meas_data;
      cnt_q      <= 2'h0;
    end
    else if (cnt_q >= lag)
    begin
      meas_valid <= 1'b1;
      meas_data  <= level;
    end
    else
      cnt_q <= cnt_q + 2'h1;
  end
endmodule

/* dv/touch_autoconfig_control_tb.sv */
// self-checking bench of the auto-configuration control
`timescale 1ns/1ns
`include "autocfg_defines.svh"
module touch_autoconfig_control_tb;
  logic                    clk_sys, rst_n, read, write, waitrequest, irq;
  logic                    meas_req, meas_valid, busy;
  logic [7:0]              address, meas_data, level, last_load;
  logic [31:0]             writedata, readdata;
  logic [1:0]              lag;
  logic [5:0]              exp_smp;
  logic [7:0][7:0]         baseline;
  logic [7:0][8:0]         setting;
  autocfg_pkg::meas_cmd_s  meas_cmd;
  autocfg_pkg::base_load_s base_load;
  int                      fail_count, n_compared, n_samp, n_load, bad_smp;

  touch_autoconfig_control u_dut (.clk_sys, .rst_n, .address, .read, .write, .writedata,
    .byteenable(4'hf), .readdata, .waitrequest, .irq, .meas_req, .meas_cmd, .meas_valid,
    .meas_data, .baseline, .base_load, .setting, .busy);
  frontend_model u_fe (.clk_sys, .rst_n, .meas_req, .meas_cmd, .level, .lag, .meas_valid,
    .meas_data);

  // count samples and baseline loads as the design sees them
  always @(posedge clk_sys)
  begin
    if (meas_valid && meas_req)
    begin
      n_samp++;
      if (meas_cmd.samples !== exp_smp)
        bad_smp++;
    end
    if (base_load.load === 1'b1)
    begin
      n_load++;
      last_load = base_load.value;
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int k;
    @(posedge clk_sys);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= wr;
    read      <= !wr;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 50);
    q = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
    if (k >= 50)
    begin
      fail_count++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(name, {24'h0, q}, {24'h0, exp});
  endtask

  // wait for n samples, then a quiet spell proves no more follow
  task automatic wait_samp(input int n);
    int k;
    for (k = 0; k < 20000 && n_samp < n; k++)
      @(posedge clk_sys);
    if (k >= 20000)
    begin
      fail_count++;
      conclude();
    end
    repeat (12) @(posedge clk_sys);
    chk("sample count", n_samp, n);
    chk("busy", busy, 1'b0);
  endtask

  task automatic run(input logic [7:0] ctrl, input int n);
    n_samp = 0;
    n_load = 0;
    wr(`OFS_CTRL, ctrl);
    wait_samp(n);
  endtask

  task automatic t_regs();
    rd("target rst", `OFS_TARGET, 8'h00);
    rd("lower rst", `OFS_LOWER, 8'h00);
    rd("upper rst", `OFS_UPPER, 8'h00);
    rd("ctrl rst", `OFS_CTRL, 8'h00);
    rd("unmapped", 8'h20, 8'h00);
    wr(`OFS_TARGET, 8'hff);
    wr(`OFS_LOWER, 8'ha5);
    wr(`OFS_UPPER, 8'h5a);
    rd("target", `OFS_TARGET, 8'hff);
    rd("lower", `OFS_LOWER, 8'ha5);
    rd("upper", `OFS_UPPER, 8'h5a);
    wr(`OFS_TARGET, 8'h8c);
    wr(`OFS_LOWER, 8'h65);
    wr(`OFS_UPPER, 8'h9c);
  endtask

  // every sample count and baseline action; 7 samples per passing electrode
  task automatic t_adjust();
    logic [5:0] smp[4] = '{6'h06, 6'h0a, 6'h12, 6'h22};
    logic [7:0] ld[4] = '{8'h00, 8'h00, 8'h90, 8'h93};
    for (int i = 0; i < 4; i++)
    begin
      exp_smp = smp[i];
      lag <= i[1:0];
      bad_smp = 0;
      run({i[1:0], 2'b00, i[1:0], 2'b01}, 56);
      chk("sample setup", bad_smp, 0);
      chk("loads", n_load, (i == 0) ? 0 : 8);
      if (i != 0)
        chk("load value", last_load, ld[i]);
      rd("range ok", `OFS_RANGE_STS, 8'h00);
    end
  endtask

  // inverted limits fail everywhere; retry doubles the search
  task automatic t_fail();
    exp_smp = 6'h06;
    bad_smp = 0;
    wr(`OFS_LOWER, 8'h20);
    wr(`OFS_UPPER, 8'h10);
    for (int r = 0; r < 4; r++)
    begin
      run({2'b00, r[1:0], 4'b0001}, (r == 0) ? 392 : 784);
      rd("range fail", `OFS_RANGE_STS, 8'hff);
      rd("fail flags", `OFS_FAIL_STS, 8'h40);
    end
    @(negedge clk_sys);
    chk("irq masked", irq, 1'b0);
    wr(`OFS_IRQ_MASK, 8'h02);
    @(negedge clk_sys);
    chk("irq on", irq, 1'b1);
    rd("irq sts set", `OFS_IRQ_STS, 8'h03);
    wr(`OFS_IRQ_STS, 8'h03);
    @(negedge clk_sys);
    chk("irq clr", irq, 1'b0);
    rd("irq sts", `OFS_IRQ_STS, 8'h00);
    wr(`OFS_IRQ_MASK, 8'h00);
  endtask

  // drift only restarts a search while reconfiguration is enabled
  task automatic t_recfg();
    wr(`OFS_LOWER, 8'h65);
    wr(`OFS_UPPER, 8'h9c);
    run(8'h0b, 56);
    rd("flags clr", `OFS_FAIL_STS, 8'h00);
    run(8'h08, 0);
    level <= 8'h00;
    baseline[2] <= 8'h10;
    wait_samp(0);
    run(8'h0a, 49);
    rd("range ele2", `OFS_RANGE_STS, 8'h04);
    rd("recfg flag", `OFS_FAIL_STS, 8'h80);
    // high level drops every trial bit, zero level keeps them all
    chk("setting ele0", setting[0], 9'h040);
    chk("setting ele2", setting[2], 9'h1ff);
    chk("sample setup", bad_smp, 0);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // main sequence
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    n_samp = 0;
    n_load = 0;
    bad_smp = 0;
    exp_smp = 6'h06;
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    level = 8'h93;
    lag = 2'h0;
    baseline = {8{8'h80}};
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_adjust();
    t_fail();
    t_recfg();
    conclude();
  end
endmodule
